// ===== core/fpwm_defs.svh
// fan pwm block: register indices, field positions, reset values, rates
// assumes a 100 MHz core clock; byte address of a register is 4 x index
`ifndef FPWM_DEFS_SVH
`define FPWM_DEFS_SVH

`define FPWM_CORE_HZ 100000000
`define FPWM_BASE_FAST_HZ 360000
`define FPWM_BASE_SLOW_HZ 1400
`define FPWM_HIRES_HZ 22500
`define FPWM_HIRES_STEPS 255
`define FPWM_DIV_FAST \
  ((`FPWM_CORE_HZ + `FPWM_BASE_FAST_HZ / 2) / `FPWM_BASE_FAST_HZ)
`define FPWM_DIV_SLOW \
  ((`FPWM_CORE_HZ + `FPWM_BASE_SLOW_HZ / 2) / `FPWM_BASE_SLOW_HZ)
`define FPWM_DIV_HIRES (`FPWM_CORE_HZ / (`FPWM_HIRES_HZ * `FPWM_HIRES_STEPS))

`define FPWM_IDX_ENH 8'h45
`define FPWM_IDX_CFG 8'h4a
`define FPWM_IDX_DUTY 8'h4c
`define FPWM_IDX_FREQ 8'h4d
`define FPWM_IDX_STAT 8'h50

`define FPWM_HIRES_SEL_BIT 4
`define FPWM_BASE_SEL_BIT 3
`define FPWM_HIRES_FREQ 8'h08
`define FPWM_HIRES_FULL 8'hff

`define FPWM_RST_ENH 8'h00
`define FPWM_RST_CFG 8'h00
`define FPWM_RST_DUTY 8'h00
`define FPWM_RST_FREQ 8'h17

`define FPWM_RESP_OKAY 2'b00
`define FPWM_RESP_SLVERR 2'b10

`endif

// ===== core/fpwm_pkg.sv
// fan pwm block: shared types
// constants live in fpwm_defs.svh
package fpwm_pkg;

  typedef enum logic [1:0] {
    FPWM_MODE_NORM = 2'b01,
    FPWM_MODE_HIRES = 2'b10
  } fpwm_mode_type;

  // software-visible configuration
  typedef struct packed {
    logic [7:0] enh;
    logic [7:0] cfg;
    logic [7:0] duty;
    logic [7:0] freq;
  } fpwm_regs_type;

  // settings frozen for one pwm period
  typedef struct packed {
    fpwm_mode_type mode;
    logic [7:0] full;
    logic [7:0] duty;
  } fpwm_period_type;

endpackage : fpwm_pkg

// ===== core/fpwm_tick.sv
// fan pwm block: step tick divider
// one-cycle tick every div core cycles; div must be at least 1
`timescale 1ns/1ps
module fpwm_tick import fpwm_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [16:0] div,
  output logic tick
);
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic end_w;

  // >= so a divisor shrunk mid-count cannot strand the counter
  assign end_w = (cnt_r >= div - 17'h00001);
  assign cnt_nxt = end_w ? 17'h00000 : cnt_r + 17'h00001;
  assign tick = ce & end_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 17'h00000;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : fpwm_tick

// ===== core/fpwm_top.sv
// fan pwm block: axi4-lite register slave and pwm period generator
// assumes CORE_CLK at 100 MHz; PWM_OUT drives the fan's pwm input
// Overview of operation
// (RULE1) high-res mode needs hi-res select set, base select clear, freq 0x08
// (RULE2) high-res mode uses eight duty bits, full scale ff, 22.5 kHz; code steps every 17 core cycles, about 23.07 kHz
// (RULE3) high time fraction equals duty value over full scale
// (RULE4) normal period lasts twice the setting in base clock steps
// (RULE5) normal full scale equals twice the frequency setting
// (RULE6) frequency setting zero behaves exactly like setting one
// (RULE7) duty at or above full scale keeps output high whole period
`timescale 1ns/1ps
`include "fpwm_defs.svh"
module fpwm_top import fpwm_pkg::*; #(
  parameter int unsigned DIV_SLOW = `FPWM_DIV_SLOW
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic PWM_OUT
);

  // register selector codes
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_ENH = 3'h1;
  localparam logic [2:0] SEL_CFG = 3'h2;
  localparam logic [2:0] SEL_DUTY = 3'h3;
  localparam logic [2:0] SEL_FREQ = 3'h4;
  localparam logic [2:0] SEL_STAT = 3'h5;

  // address decode shared by the write and read paths
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[11:10] != 2'h0 || a[1:0] != 2'h0) begin
      reg_sel = SEL_NONE;
    end else if (idx == `FPWM_IDX_ENH) begin
      reg_sel = SEL_ENH;
    end else if (idx == `FPWM_IDX_CFG) begin
      reg_sel = SEL_CFG;
    end else if (idx == `FPWM_IDX_DUTY) begin
      reg_sel = SEL_DUTY;
    end else if (idx == `FPWM_IDX_FREQ) begin
      reg_sel = SEL_FREQ;
    end else if (idx == `FPWM_IDX_STAT) begin
      reg_sel = SEL_STAT;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction : reg_sel

  fpwm_regs_type regs_r;
  fpwm_period_type per_r;
  fpwm_period_type per_nxt;
  logic [11:0] aw_addr_r;
  logic aw_got_r;
  logic [7:0] w_data_r;
  logic w_en_r;
  logic w_got_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic pwm_r;
  logic pwm_nxt;

  // write channel: address and data taken in either order
  logic do_wr;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [31:0] rd_mux;
  assign S_AXI_AWREADY = CE & ~aw_got_r & ~bvalid_r;
  assign S_AXI_WREADY = CE & ~w_got_r & ~bvalid_r;
  assign do_wr = CE & aw_got_r & w_got_r & ~bvalid_r;
  assign wr_sel = reg_sel(aw_addr_r);
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_got_r <= 1'b0;
      w_data_r <= 8'h00;
      w_en_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `FPWM_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        w_data_r <= S_AXI_WDATA[7:0];
        w_en_r <= S_AXI_WSTRB[0];
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wr_sel == SEL_NONE) ? `FPWM_RESP_SLVERR
                                        : `FPWM_RESP_OKAY;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // register store; only byte lane 0 carries data, status is read-only
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      regs_r.enh <= `FPWM_RST_ENH;
      regs_r.cfg <= `FPWM_RST_CFG;
      regs_r.duty <= `FPWM_RST_DUTY;
      regs_r.freq <= `FPWM_RST_FREQ;
    end else if (do_wr && w_en_r) begin
      if (wr_sel == SEL_ENH) begin
        regs_r.enh <= w_data_r;
      end else if (wr_sel == SEL_CFG) begin
        regs_r.cfg <= w_data_r;
      end else if (wr_sel == SEL_DUTY) begin
        regs_r.duty <= w_data_r;
      end else if (wr_sel == SEL_FREQ) begin
        regs_r.freq <= w_data_r;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  assign S_AXI_ARREADY = CE & ~rvalid_r;
  assign rd_sel = reg_sel(S_AXI_ARADDR);
  assign rd_mux = (rd_sel == SEL_ENH) ? {24'h000000, regs_r.enh} :
                  (rd_sel == SEL_CFG) ? {24'h000000, regs_r.cfg} :
                  (rd_sel == SEL_DUTY) ? {24'h000000, regs_r.duty} :
                  (rd_sel == SEL_FREQ) ? {24'h000000, regs_r.freq} :
                  (rd_sel == SEL_STAT) ? {22'h000000, pwm_r,
                    (per_r.mode == FPWM_MODE_HIRES), per_r.full} :
                  32'h00000000;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `FPWM_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= (rd_sel == SEL_NONE) ? `FPWM_RESP_SLVERR
                                        : `FPWM_RESP_OKAY;
      end else if (S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // mode and full-scale selection from the live registers
  logic hires_w;
  logic [4:0] set_w;
  logic [7:0] full_w;
  logic [7:0] duty_w;
  fpwm_mode_type mode_w;
  assign hires_w = regs_r.enh[`FPWM_HIRES_SEL_BIT] &
                   ~regs_r.cfg[`FPWM_BASE_SEL_BIT] &
                   (regs_r.freq == `FPWM_HIRES_FREQ); // [RULE1]
  assign mode_w = hires_w ? FPWM_MODE_HIRES : FPWM_MODE_NORM;
  assign set_w = (regs_r.freq[4:0] == 5'h00) ? 5'h01
                                              : regs_r.freq[4:0]; // [RULE6]

  always_comb begin
    case (mode_w)
      FPWM_MODE_HIRES: begin
        full_w = `FPWM_HIRES_FULL; // [RULE2]
        duty_w = regs_r.duty;
      end
      default: begin
        full_w = {2'h0, set_w, 1'b0}; // [RULE5]
        duty_w = {2'h0, regs_r.duty[5:0]};
      end
    endcase
  end

  // step tick: hi-res step rate, else the selected base clock
  logic [16:0] div_w;
  logic tick_w;
  assign div_w = hires_w ? 17'(`FPWM_DIV_HIRES) :
                 regs_r.cfg[`FPWM_BASE_SEL_BIT] ? 17'(DIV_SLOW) :
                 17'(`FPWM_DIV_FAST);

  fpwm_tick u_tick (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .div(div_w),
    .tick(tick_w)
  );

  // period counter; full scale and duty are taken only at a period boundary so a
  // duty write never produces a runt pulse; the step divider follows the live registers
  logic wrap_w;
  assign wrap_w = tick_w & (cnt_r >= per_r.full - 8'h01); // [RULE4]
  assign cnt_nxt = wrap_w ? 8'h00 : cnt_r + 8'h01;
  assign per_nxt = wrap_w ? fpwm_period_type'{mode: mode_w, full: full_w,
                                              duty: duty_w}
                          : per_r;
  assign pwm_nxt = (cnt_nxt < per_nxt.duty) |
                   (per_nxt.duty >= per_nxt.full); // [RULE3] [RULE7]
  assign PWM_OUT = pwm_r;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 8'h00;
      per_r <= '{mode: FPWM_MODE_NORM, full: 8'h02, duty: 8'h00};
      pwm_r <= 1'b0;
    end else if (tick_w) begin
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  // checking helpers: high steps and valid flag after first boundary
  logic [7:0] hi_acc_r;
  logic chk_valid_r;
  logic [8:0] hi_total_w;
  logic [8:0] duty_clip_w;
  assign hi_total_w = {1'b0, hi_acc_r} + {8'h00, pwm_r};
  assign duty_clip_w = (per_r.duty >= per_r.full) ? {1'b0, per_r.full}
                                                  : {1'b0, per_r.duty};

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_acc_r <= 8'h00;
      chk_valid_r <= 1'b0;
    end else if (tick_w) begin
      hi_acc_r <= wrap_w ? 8'h00 : hi_acc_r + {7'h00, pwm_r};
      chk_valid_r <= chk_valid_r | wrap_w;
    end
  end

  sequence s_wrap_hires;
    wrap_w && hires_w;
  endsequence

  sequence s_wrap_norm;
    wrap_w && !hires_w;
  endsequence

  property p_hires_enter;
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_wrap_hires |=> per_r.mode == FPWM_MODE_HIRES;
  endproperty
  a_hires_enter: assert property (p_hires_enter) // [RULE1]
    else $error("hi-res mode not entered at boundary");

  property p_norm_stay;
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_wrap_norm |=> per_r.mode == FPWM_MODE_NORM;
  endproperty
  a_norm_stay: assert property (p_norm_stay) // [RULE1]
    else $error("hi-res mode entered without all conditions");

  property p_hires_full;
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_wrap_hires |=> per_r.full == 8'hff && per_r.duty == $past(regs_r.duty);
  endproperty
  a_hires_full: assert property (p_hires_full) // [RULE2]
    else $error("hi-res full scale or duty width wrong");

  property p_duty_frac;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (chk_valid_r && wrap_w) |-> hi_total_w == duty_clip_w;
  endproperty
  a_duty_frac: assert property (p_duty_frac) // [RULE3]
    else $error("high steps in period differ from duty value");

  property p_period_len;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (chk_valid_r && wrap_w) |-> {1'b0, cnt_r} + 9'h001 == {1'b0, per_r.full};
  endproperty
  a_period_len: assert property (p_period_len) // [RULE4]
    else $error("period step count differs from full scale");

  property p_norm_full;
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_wrap_norm |=> per_r.full == {2'h0, $past(set_w), 1'b0};
  endproperty
  a_norm_full: assert property (p_norm_full) // [RULE5]
    else $error("normal full scale is not twice the setting");

  property p_zero_as_one;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (s_wrap_norm and (regs_r.freq[4:0] == 5'h00)) |=> per_r.full == 8'h02;
  endproperty
  a_zero_as_one: assert property (p_zero_as_one) // [RULE6]
    else $error("setting zero not treated as one");

  property p_full_on;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (tick_w && per_nxt.duty >= per_nxt.full) |=> PWM_OUT ##1 PWM_OUT;
  endproperty
  a_full_on: assert property (p_full_on) // [RULE7]
    else $error("output low while duty at or above full scale");

endmodule : fpwm_top

// ===== testbench/fpwm_fan_model.sv
// fan pwm input model: measures high and low run lengths of the pwm line
// assumes the same clock as the pwm source; line sampled on rising edges
`timescale 1ns/1ps
module fpwm_fan_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm_in,
  output logic [31:0] hi_len,
  output logic [31:0] lo_len,
  output logic [31:0] n_rise
);
  logic [31:0] run_r;
  logic last_r;
  // a run is latched only on a change, so a steady line reports nothing new
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 32'h1;
      last_r <= 1'b0;
      hi_len <= 32'h0;
      lo_len <= 32'h0;
      n_rise <= 32'h0;
    end else if (pwm_in !== last_r) begin
      run_r <= 32'h1;
      last_r <= pwm_in;
      if (pwm_in) begin
        lo_len <= run_r;
        n_rise <= n_rise + 32'h1;
      end else begin
        hi_len <= run_r;
      end
    end else begin
      run_r <= run_r + 32'h1;
    end
  end
endmodule : fpwm_fan_model

// ===== testbench/tb_top.sv
// fan pwm testbench: axi4-lite master, row table, reset and edge cases
// assumes fpwm_top with a short slow divisor; fan model measures PWM_OUT
`timescale 1ns/1ps
`include "fpwm_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top import fpwm_pkg::*;;
  localparam int DS = 5;
  localparam int LIM = 60000;
  typedef struct packed {
    logic [7:0] enh, cfg, freq, duty;
    int hs, full, dv;
    bit hr;
  } fpwm_row_type;
  // enh cfg freq duty, steps high, full scale, step cycles, hi-res
  fpwm_row_type rows [7] = '{
    '{8'h00, 8'h08, 8'h18, 8'h1c, 28, 48, DS, 0},
    '{8'h00, 8'h08, 8'h1f, 8'h2f, 47, 62, DS, 0},
    '{8'h00, 8'h08, 8'h00, 8'h01, 1, 2, DS, 0},
    '{8'h10, 8'h08, 8'h08, 8'h03, 3, 16, DS, 0},
    '{8'h00, 8'h08, 8'h18, 8'h45, 5, 48, DS, 0},
    '{8'h10, 8'h00, 8'h08, 8'hbf, 191, 255, 17, 1},
    '{8'h10, 8'h00, 8'h21, 8'h01, 1, 2, 278, 0}};
  logic clk = 0, rst_n = 0, ce = 1, pwm;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata, hi_len, lo_len, n_rise;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  int n_fail = 0, n_tests = 0, cyc = 0, k;
  logic [31:0] r0;
  always #5 clk = ~clk;
  fpwm_top #(.DIV_SLOW(DS)) fpwm_top_inst (.CORE_CLK(clk), .RST_N(rst_n),
    .CE(ce), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PWM_OUT(pwm));
  fpwm_fan_model fpwm_fan_model_inst (.clk(clk), .rst_n(rst_n),
    .pwm_in(pwm), .hi_len(hi_len), .lo_len(lo_len), .n_rise(n_rise));
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  // address and data go out together; each drops when its channel takes it
  task automatic wr(input logic [7:0] i, input logic [7:0] v,
      input logic [3:0] s, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= ba(i);
    awvalid <= 1;
    wdata <= {24'h0, v};
    wstrb <= s;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        rs = bresp;
        bready <= 0;
        done = 1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] v,
      output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= ba(i);
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 0;
        done = 1;
      end
    end
  endtask : rd
  // counts cycles in which the pwm line is not at level lv; an unknown
  // level counts as well, so a dead output cannot pass as a steady one
  task automatic cnt(input int n, input logic lv, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (pwm !== lv) c++;
    end
  endtask : cnt
  // a hung handshake or a silent pwm line ends here as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rd(`FPWM_IDX_FREQ, d, r);
    `CHK("freq reset", 32'h17, d)
    rd(`FPWM_IDX_DUTY, d, r);
    `CHK("duty reset", 32'h0, d)
    wr(8'h80, 8'h11, 4'h1, r);
    `CHK("unmapped bresp", `FPWM_RESP_SLVERR, r)
    rd(8'h80, d, r);
    `CHK("unmapped rresp", `FPWM_RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0, d)
    wr(`FPWM_IDX_FREQ, 8'h05, 4'h0, r);
    rd(`FPWM_IDX_FREQ, d, r);
    `CHK("masked write", 32'h17, d)
    wr(`FPWM_IDX_STAT, 8'h33, 4'h1, r);
    `CHK("status bresp", `FPWM_RESP_OKAY, r)
    foreach (rows[i]) begin
      wr(`FPWM_IDX_ENH, rows[i].enh, 4'h1, r);
      wr(`FPWM_IDX_CFG, rows[i].cfg, 4'h1, r);
      wr(`FPWM_IDX_FREQ, rows[i].freq, 4'h1, r);
      wr(`FPWM_IDX_DUTY, rows[i].duty, 4'h1, r);
      // two whole periods must pass so old settings drain out
      r0 = n_rise;
      while (n_rise < r0 + 3) @(posedge clk);
      while (pwm === 1'b1) @(posedge clk);
      @(posedge clk);
      `CHK("high len", 32'(rows[i].hs * rows[i].dv), hi_len)
      k = rows[i].dv * (rows[i].full - rows[i].hs);
      `CHK("low len", 32'(k), lo_len)
      rd(`FPWM_IDX_STAT, d, r);
      `CHK("status", {rows[i].hr, 8'(rows[i].full)}, d[8:0])
    end
    wr(`FPWM_IDX_CFG, 8'h08, 4'h1, r);
    wr(`FPWM_IDX_FREQ, 8'h02, 4'h1, r);
    wr(`FPWM_IDX_DUTY, 8'h00, 4'h1, r);
    repeat (700) @(posedge clk);
    cnt(60, 1'b0, k);
    `CHK("zero duty highs", 0, k)
    wr(`FPWM_IDX_DUTY, 8'h0a, 4'h1, r);
    repeat (60) @(posedge clk);
    cnt(60, 1'b1, k);
    `CHK("full duty lows", 0, k)
    @(posedge clk);
    ce <= 0;
    @(posedge clk);
    @(posedge clk);
    `CHK("arready frozen", 1'b0, arready)
    ce <= 1;
    rst_n <= 0;
    repeat (3) @(posedge clk);
    `CHK("pwm in reset", 1'b0, pwm)
    rst_n <= 1;
    rd(`FPWM_IDX_DUTY, d, r);
    `CHK("duty after reset", 32'h0, d)
    end_sim();
  end
endmodule : tb_top
